// file: shared/sep_params.svh
// Constants of the serial word memory link
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH
`define SEP_WORDS 64
`define SEP_WIDTH 16
`define SEP_ADDR_W 6
`define SEP_HDR_BITS 8
`define SEP_FRAME_BITS 25
`define SEP_ERASED 16'hFFFF
`define SEP_OPC_EXT 2'h0
`define SEP_OPC_WRITE 2'h1
`define SEP_OPC_READ 2'h2
`define SEP_OPC_ERASE 2'h3
`define SEP_SUB_DIS 2'h0
`define SEP_SUB_WR_ALL 2'h1
`define SEP_SUB_ER_ALL 2'h2
`define SEP_SUB_EN 2'h3
`define SEP_CLK_NS 20
`define SEP_CLK_KHZ 50000
`define SEP_T_PROG_MS 15
`define SEP_PROG_CYC (`SEP_T_PROG_MS * `SEP_CLK_KHZ)
`define SEP_T_SCLK_NS 5000
`define SEP_SCLK_HALF_CYC ((`SEP_T_SCLK_NS / 2 + `SEP_CLK_NS - 1) / `SEP_CLK_NS)
`define SEP_T_CS_NS 1000
`define SEP_CS_CYC ((`SEP_T_CS_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS)
`define SEP_T_SV_NS 1000
`define SEP_SV_CYC ((`SEP_T_SV_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS)
`endif

// file: shared/sep_pkg.sv
// Types and shared decode for the serial word memory link
`include "sep_params.svh"
package sep_pkg;
   typedef logic [`SEP_WIDTH-1:0] sep_word_t;
   typedef enum logic [2:0] {D_IDLE, D_RX, D_DATA, D_ARM, D_PROG, D_READY, D_TX, D_HOLD} sep_dev_state_t;
   typedef enum logic [2:0] {C_IDLE, C_LOW, C_HIGH, C_GAP, C_POLL, C_REST} sep_ctl_state_t;

   // True for the four instructions that start a programming cycle
   function automatic logic sep_is_prog(input logic [1:0] opc, input logic [1:0] sub);
      if (opc == `SEP_OPC_READ) begin
         return 1'b0;
      end
      if (opc == `SEP_OPC_EXT) begin
         return (sub == `SEP_SUB_ER_ALL) || (sub == `SEP_SUB_WR_ALL);
      end
      return 1'b1;
   endfunction : sep_is_prog

   // True where sixteen data bits follow the header
   function automatic logic sep_has_data(input logic [1:0] opc, input logic [1:0] sub);
      return (opc == `SEP_OPC_WRITE) || ((opc == `SEP_OPC_EXT) && (sub == `SEP_SUB_WR_ALL));
   endfunction : sep_has_data
endpackage : sep_pkg

// file: shared/sep_if.sv
// Three-wire link between controller and memory
`timescale 1ns/1ps
interface sep_if;
   logic select;
   logic shift_clock;
   logic serial_in;
   logic serial_out;
   logic serial_out_oe_n;
   logic serial_line;

   // Pull-up resolves the undriven output
   assign serial_line = serial_out_oe_n ? 1'b1 : serial_out;

   modport dev (input select, input shift_clock, input serial_in, output serial_out, output serial_out_oe_n);
   modport ctl (output select, output shift_clock, output serial_in, input serial_line);
endinterface : sep_if

// file: core/sep_sync.sv
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
module sep_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] d_out
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_reg <= '0;
         d_out <= '0;
      end else begin
         meta_reg <= d_in;
         d_out <= meta_reg;
      end
   end
endmodule : sep_sync

// file: core/sep_dev.sv
// Memory end: instruction decode, 64x16 array, self-timed programming
//
// Behaviour
// - Array of 64 words, 16 bits each
// - Instruction: start one, opcode, address, MSB first
// - Opcodes 10 read, 01 write, 11 erase
// - Opcode 00 sub-decoded by two upper address bits
// - Read sends zero dummy then 16 bits
// - Read output changes only on shift clock rise
// - Output released except read and status
// - Powers up disabled; enable instruction sets, disable instruction clears
// - Read works regardless of enable state
// - Erase starts on select fall, sets ones
// - Status low while busy, high when done
// - Controller lowers select after last data bit
// - Write only clears bits; word must be erased before writing it
// - Erase-all sets all words, erase sequence
// - Write-all writes every word, write sequence
// - Shift clock may stop during programming
// - Select low at least 1 us between instructions
// - Shift clock period at least 5 us
// - Programming cycle internally timed, within 15 ms
`timescale 1ns/1ps
`include "sep_params.svh"
module sep_dev import sep_pkg::*; #(
   parameter int unsigned PROG_CYCLES = `SEP_PROG_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   sep_if.dev link,
   output logic prog_enabled,
   output logic prog_busy
);
   localparam int TW = $clog2(PROG_CYCLES + 1);

   logic s_sel;
   logic s_sclk;
   logic s_si;
   logic sclk_rise;
   logic cs_fall;
   logic [7:0] hdr_shift;

   sep_dev_state_t state_reg, state_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [7:0] hdr_reg, hdr_next;
   sep_word_t dat_reg, dat_next;
   sep_word_t out_reg, out_next;
   logic so_reg, so_next;
   logic oe_n_reg, oe_n_next;
   logic en_reg, en_next;
   logic busy_reg, busy_next;
   logic [TW-1:0] timer_reg, timer_next;
   logic sclk_d_reg;
   logic cs_d_reg;
   sep_word_t mem_reg [`SEP_WORDS];
   sep_word_t mem_next [`SEP_WORDS];

   sep_sync #(.WIDTH(3)) u_sync (
      .mclk(mclk),
      .rst(rst),
      .d_in({link.select, link.shift_clock, link.serial_in}),
      .d_out({s_sel, s_sclk, s_si})
   );

   assign sclk_rise = s_sclk & ~sclk_d_reg;
   assign cs_fall = ~s_sel & cs_d_reg;
   assign hdr_shift = {hdr_reg[6:0], s_si};

   assign link.serial_out = so_reg;
   assign link.serial_out_oe_n = oe_n_reg;
   assign prog_enabled = en_reg;
   assign prog_busy = busy_reg;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      hdr_next = hdr_reg;
      dat_next = dat_reg;
      out_next = out_reg;
      so_next = so_reg;
      oe_n_next = 1'b1;
      en_next = en_reg;
      timer_next = timer_reg;
      for (int i = 0; i < `SEP_WORDS; i++) begin
         mem_next[i] = mem_reg[i];
      end
      case (state_reg)
         D_IDLE: begin
            if (s_sel && sclk_rise && s_si) begin
               state_next = D_RX;
               cnt_next = '0;
            end
         end
         D_RX: begin
            if (!s_sel) begin
               state_next = D_IDLE;
            end else if (sclk_rise) begin
               hdr_next = hdr_shift;
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == 5'(`SEP_HDR_BITS - 1)) begin
                  cnt_next = '0;
                  if (hdr_shift[7:6] == `SEP_OPC_READ) begin
                     out_next = mem_reg[hdr_shift[5:0]];
                     so_next = 1'b0;
                     oe_n_next = 1'b0;
                     state_next = D_TX;
                  end else if (hdr_shift[7:6] == `SEP_OPC_EXT && hdr_shift[5:4] == `SEP_SUB_EN) begin
                     en_next = 1'b1;
                     state_next = D_HOLD;
                  end else if (hdr_shift[7:6] == `SEP_OPC_EXT && hdr_shift[5:4] == `SEP_SUB_DIS) begin
                     en_next = 1'b0;
                     state_next = D_HOLD;
                  end else if (!en_reg) begin
                     state_next = D_HOLD;
                  end else if (sep_has_data(hdr_shift[7:6], hdr_shift[5:4])) begin
                     state_next = D_DATA;
                  end else begin
                     state_next = D_ARM;
                  end
               end
            end
         end
         D_DATA: begin
            // Select dropped before all 16 bits leaves the array alone
            if (!s_sel) begin
               state_next = D_IDLE;
            end else if (sclk_rise) begin
               dat_next = {dat_reg[14:0], s_si};
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == 5'(`SEP_WIDTH - 1)) begin
                  state_next = D_ARM;
               end
            end
         end
         D_ARM: begin
            if (cs_fall) begin
               timer_next = TW'(PROG_CYCLES - 1);
               state_next = D_PROG;
            end else if (s_sel && sclk_rise) begin
               // Extra clock after the frame: instruction is void
               state_next = D_HOLD;
            end
         end
         D_PROG: begin
            so_next = 1'b0;
            oe_n_next = ~s_sel;
            if (timer_reg == '0) begin
               state_next = D_READY;
               for (int i = 0; i < `SEP_WORDS; i++) begin
                  case (hdr_reg[7:6])
                     `SEP_OPC_ERASE: begin
                        if (hdr_reg[5:0] == 6'(i)) begin
                           mem_next[i] = `SEP_ERASED;
                        end
                     end
                     `SEP_OPC_WRITE: begin
                        // Programming only clears bits
                        if (hdr_reg[5:0] == 6'(i)) begin
                           mem_next[i] = mem_reg[i] & dat_reg;
                        end
                     end
                     `SEP_OPC_EXT: begin
                        if (hdr_reg[5:4] == `SEP_SUB_ER_ALL) begin
                           mem_next[i] = `SEP_ERASED;
                        end else begin
                           mem_next[i] = mem_reg[i] & dat_reg;
                        end
                     end
                     default: begin
                        mem_next[i] = mem_reg[i];
                     end
                  endcase
               end
            end else begin
               timer_next = timer_reg - TW'(1);
            end
         end
         D_READY: begin
            so_next = 1'b1;
            oe_n_next = ~s_sel;
            if (s_sel && sclk_rise && s_si) begin
               oe_n_next = 1'b1;
               state_next = D_RX;
               cnt_next = '0;
            end else if (cs_fall) begin
               state_next = D_IDLE;
            end
         end
         D_TX: begin
            oe_n_next = ~s_sel;
            if (!s_sel) begin
               state_next = D_IDLE;
            end else if (sclk_rise) begin
               so_next = out_reg[15];
               out_next = {out_reg[14:0], 1'b0};
            end
         end
         D_HOLD: begin
            if (!s_sel) begin
               state_next = D_IDLE;
            end
         end
         default: begin
            state_next = D_IDLE;
         end
      endcase
      busy_next = (state_next == D_PROG);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= D_IDLE;
         cnt_reg <= '0;
         hdr_reg <= '0;
         dat_reg <= '0;
         out_reg <= '0;
         so_reg <= 1'b0;
         oe_n_reg <= 1'b1;
         en_reg <= 1'b0;
         busy_reg <= 1'b0;
         timer_reg <= '0;
         sclk_d_reg <= 1'b0;
         cs_d_reg <= 1'b0;
         for (int i = 0; i < `SEP_WORDS; i++) begin
            mem_reg[i] <= `SEP_ERASED;
         end
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         hdr_reg <= hdr_next;
         dat_reg <= dat_next;
         out_reg <= out_next;
         so_reg <= so_next;
         oe_n_reg <= oe_n_next;
         en_reg <= en_next;
         busy_reg <= busy_next;
         timer_reg <= timer_next;
         sclk_d_reg <= s_sclk;
         cs_d_reg <= s_sel;
         mem_reg <= mem_next;
      end
   end
endmodule : sep_dev

// file: core/sep_ctl.sv
// Controller end: frames instructions, reads data, polls status
`timescale 1ns/1ps
`include "sep_params.svh"
module sep_ctl import sep_pkg::*; (
   input wire logic mclk,
   input wire logic rst,
   sep_if.ctl link,
   input wire logic req,
   input wire logic [1:0] req_opc,
   input wire logic [5:0] req_addr,
   input wire logic [15:0] req_data,
   output logic ready,
   output logic done,
   output logic [15:0] rd_data
);
   logic s_line;

   sep_ctl_state_t state_reg, state_next;
   logic [7:0] tmr_reg, tmr_next;
   logic [4:0] bit_reg, bit_next;
   logic [4:0] nbit_reg, nbit_next;
   logic [24:0] tx_reg, tx_next;
   logic prog_reg, prog_next;
   logic rd_reg, rd_next;
   sep_word_t rdat_reg, rdat_next;
   logic cs_reg, cs_next;
   logic sclk_reg, sclk_next;
   logic sin_reg, sin_next;
   logic done_reg, done_next;
   logic rdy_reg, rdy_next;

   sep_sync #(.WIDTH(1)) u_sync (
      .mclk(mclk),
      .rst(rst),
      .d_in(link.serial_line),
      .d_out(s_line)
   );

   assign link.select = cs_reg;
   assign link.shift_clock = sclk_reg;
   assign link.serial_in = sin_reg;
   assign ready = rdy_reg;
   assign done = done_reg;
   assign rd_data = rdat_reg;

   always_comb begin
      state_next = state_reg;
      tmr_next = tmr_reg;
      bit_next = bit_reg;
      nbit_next = nbit_reg;
      tx_next = tx_reg;
      prog_next = prog_reg;
      rd_next = rd_reg;
      rdat_next = rdat_reg;
      cs_next = cs_reg;
      sclk_next = sclk_reg;
      sin_next = sin_reg;
      done_next = 1'b0;
      rdy_next = 1'b0;
      case (state_reg)
         C_IDLE: begin
            rdy_next = 1'b1;
            if (req) begin
               tx_next = {1'b1, req_opc, req_addr, req_data};
               rd_next = (req_opc == `SEP_OPC_READ);
               prog_next = sep_is_prog(req_opc, req_addr[5:4]);
               // Data bits follow read, write and write-all
               nbit_next = (rd_next || sep_has_data(req_opc, req_addr[5:4])) ?
                  5'(`SEP_FRAME_BITS) : 5'(`SEP_HDR_BITS + 1);
               bit_next = '0;
               cs_next = 1'b1;
               tmr_next = 8'(`SEP_SCLK_HALF_CYC - 1);
               rdy_next = 1'b0;
               state_next = C_LOW;
            end
         end
         C_LOW: begin
            sclk_next = 1'b0;
            sin_next = tx_reg[24];
            if (tmr_reg == '0) begin
               sclk_next = 1'b1;
               tmr_next = 8'(`SEP_SCLK_HALF_CYC - 1);
               state_next = C_HIGH;
            end else begin
               tmr_next = tmr_reg - 8'h01;
            end
         end
         C_HIGH: begin
            if (tmr_reg == '0) begin
               sclk_next = 1'b0;
               tx_next = {tx_reg[23:0], 1'b0};
               bit_next = bit_reg + 5'h01;
               // Sample just before the fall, far from the change
               if (rd_reg && bit_reg >= 5'(`SEP_HDR_BITS + 1)) begin
                  rdat_next = {rdat_reg[14:0], s_line};
               end
               if (bit_reg == nbit_reg - 5'h01) begin
                  cs_next = 1'b0;
                  sin_next = 1'b0;
                  tmr_next = 8'(`SEP_CS_CYC - 1);
                  state_next = prog_reg ? C_GAP : C_REST;
               end else begin
                  tmr_next = 8'(`SEP_SCLK_HALF_CYC - 1);
                  state_next = C_LOW;
               end
            end else begin
               tmr_next = tmr_reg - 8'h01;
            end
         end
         C_GAP: begin
            if (tmr_reg == '0) begin
               cs_next = 1'b1;
               tmr_next = 8'(`SEP_SV_CYC - 1);
               state_next = C_POLL;
            end else begin
               tmr_next = tmr_reg - 8'h01;
            end
         end
         C_POLL: begin
            // Status is trusted only after it had time to settle
            if (tmr_reg != '0) begin
               tmr_next = tmr_reg - 8'h01;
            end else if (s_line) begin
               cs_next = 1'b0;
               tmr_next = 8'(`SEP_CS_CYC - 1);
               state_next = C_REST;
            end
         end
         C_REST: begin
            if (tmr_reg == '0) begin
               done_next = 1'b1;
               rdy_next = 1'b1;
               state_next = C_IDLE;
            end else begin
               tmr_next = tmr_reg - 8'h01;
            end
         end
         default: begin
            state_next = C_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= C_IDLE;
         tmr_reg <= '0;
         bit_reg <= '0;
         nbit_reg <= '0;
         tx_reg <= '0;
         prog_reg <= 1'b0;
         rd_reg <= 1'b0;
         rdat_reg <= '0;
         cs_reg <= 1'b0;
         sclk_reg <= 1'b0;
         sin_reg <= 1'b0;
         done_reg <= 1'b0;
         rdy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         tmr_reg <= tmr_next;
         bit_reg <= bit_next;
         nbit_reg <= nbit_next;
         tx_reg <= tx_next;
         prog_reg <= prog_next;
         rd_reg <= rd_next;
         rdat_reg <= rdat_next;
         cs_reg <= cs_next;
         sclk_reg <= sclk_next;
         sin_reg <= sin_next;
         done_reg <= done_next;
         rdy_reg <= rdy_next;
      end
   end
endmodule : sep_ctl

// file: tb/sep_checker.sv
// Checker: link timing and output behaviour seen on the interface wires
`timescale 1ns/1ps
`include "sep_params.svh"
module sep_checker #(
   parameter int unsigned PROG_CYCLES = `SEP_PROG_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic select,
   input wire logic shift_clock,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe_n
);
   logic sclk_q_reg, sclk_q_next;
   logic [9:0] per_cnt_reg, per_cnt_next;
   logic [9:0] lo_cnt_reg, lo_cnt_next;
   logic [7:0] rise_cnt_reg, rise_cnt_next;
   logic [19:0] busy_cnt_reg, busy_cnt_next;
   logic sclk_rise;

   // Counters saturate so long idle gaps never wrap into false short gaps
   always_comb begin
      sclk_rise = shift_clock && !sclk_q_reg;
      sclk_q_next = shift_clock;
      per_cnt_next = sclk_rise ? 10'h000 : per_cnt_reg + {9'h000, per_cnt_reg != 10'h3FF};
      lo_cnt_next = select ? 10'h000 : lo_cnt_reg + {9'h000, lo_cnt_reg != 10'h3FF};
      rise_cnt_next = sclk_rise ? 8'h00 : rise_cnt_reg + {7'h00, rise_cnt_reg != 8'hFF};
      busy_cnt_next = 20'h00000;
      if (select && !serial_out_oe_n && !serial_out && !shift_clock) begin
         busy_cnt_next = busy_cnt_reg + {19'h00000, busy_cnt_reg != 20'hFFFFF};
      end
   end

   // Reset to saturated gaps: first select rise after reset is legal
   always_ff @(posedge mclk) begin
      if (rst) begin
         sclk_q_reg <= 1'b0;
         per_cnt_reg <= 10'h3FF;
         lo_cnt_reg <= 10'h3FF;
         rise_cnt_reg <= 8'hFF;
         busy_cnt_reg <= 20'h00000;
      end else begin
         sclk_q_reg <= sclk_q_next;
         per_cnt_reg <= per_cnt_next;
         lo_cnt_reg <= lo_cnt_next;
         rise_cnt_reg <= rise_cnt_next;
         busy_cnt_reg <= busy_cnt_next;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence sclk_quiet;
      !shift_clock [*8];
   endsequence
   sequence stat_ready;
      (serial_out || serial_out_oe_n) [*8];
   endsequence

   sel_gap_a: assert property ($rose(select) |-> lo_cnt_reg >= 10'(`SEP_CS_CYC))
      else $error("select low time too short");
   sclk_period_a: assert property ($rose(shift_clock) |-> per_cnt_reg >= 10'(2 * `SEP_SCLK_HALF_CYC - 1))
      else $error("shift clock period too short");
   din_stable_a: assert property (shift_clock && $past(shift_clock) |-> $stable(serial_in))
      else $error("serial input moved while shift clock high");
   out_release_a: assert property (lo_cnt_reg >= 10'h008 |-> serial_out_oe_n)
      else $error("serial output driven with select low");
   out_on_rise_a: assert property (!serial_out_oe_n && !$past(serial_out_oe_n) && $changed(serial_out) && shift_clock
      |-> rise_cnt_reg <= 8'h08)
      else $error("read bit changed without a shift clock rise");
   dummy_zero_a: assert property ($fell(serial_out_oe_n) && shift_clock |-> !serial_out)
      else $error("read output did not start with a zero");
   busy_bound_a: assert property (busy_cnt_reg < PROG_CYCLES + 60)
      else $error("busy status held too long");
   ready_hold_a: assert property ($rose(serial_out) && select && !serial_out_oe_n && !shift_clock |-> stat_ready)
      else $error("ready status fell back to busy");
   sel_rise_a: assert property ($rose(select) |-> sclk_quiet)
      else $error("shift clock not low after select rise");
endmodule : sep_checker

// file: tb/tb.sv
// Testbench: controller and memory ends joined across the three-wire link
`timescale 1ns/1ps
`include "sep_params.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("ERROR %0t: got %h exp %h", $time, (got), (exp)); end end
module tb;
   localparam int unsigned PROG = 200;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic req = 1'b0;
   logic [1:0] req_opc = 2'h0;
   logic [5:0] req_addr = 6'h00;
   logic [15:0] req_data = 16'h0000;
   logic ready, done, prog_enabled, prog_busy;
   logic [15:0] rd_data;
   logic busy_seen = 1'b0;
   logic sclk_q = 1'b0;
   logic [24:0] din_sh = 25'h0000000;
   logic [16:0] dout_sh = 17'h00000;
   int stat_lo = 0;
   int n_errors = 0;
   int total_checks = 0;

   sep_if link ();
   sep_dev #(.PROG_CYCLES(PROG)) u_sep_dev (.mclk(mclk), .rst(rst), .link(link.dev),
      .prog_enabled(prog_enabled), .prog_busy(prog_busy));
   sep_ctl u_sep_ctl (.mclk(mclk), .rst(rst), .link(link.ctl), .req(req), .req_opc(req_opc),
      .req_addr(req_addr), .req_data(req_data), .ready(ready), .done(done), .rd_data(rd_data));
   sep_checker #(.PROG_CYCLES(PROG)) u_sep_checker (.mclk(mclk), .rst(rst), .select(link.select),
      .shift_clock(link.shift_clock), .serial_in(link.serial_in), .serial_out(link.serial_out),
      .serial_out_oe_n(link.serial_out_oe_n));

   always #10 mclk = ~mclk;

   // Wire monitor: input bits at clock rises, resolved output at falls
   always @(posedge mclk) begin
      if (prog_busy === 1'b1) busy_seen = 1'b1;
      if (link.select && !link.serial_out_oe_n && !link.serial_out && !link.shift_clock) stat_lo++;
      if (link.shift_clock && !sclk_q) din_sh = {din_sh[23:0], link.serial_in};
      if (!link.shift_clock && sclk_q) dout_sh = {dout_sh[15:0], link.serial_line};
      sclk_q = link.shift_clock;
   end

   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   task automatic tick(inout int i);
      @(posedge mclk);
      #1;
      i++;
      if (i > 20000) begin
         n_errors++;
         $display("ERROR %0t: handshake timed out", $time);
         test_done();
      end
   endtask : tick

   // One instruction through the user port, waits for its done pulse
   task automatic op(input logic [1:0] opc, input logic [5:0] addr, input logic [15:0] data);
      int i;
      i = 0;
      while (ready !== 1'b1) tick(i);
      @(posedge mclk);
      req <= 1'b1;
      req_opc <= opc;
      req_addr <= addr;
      req_data <= data;
      @(posedge mclk);
      req <= 1'b0;
      #1;
      i = 0;
      while (done !== 1'b1) tick(i);
   endtask : op

   task automatic rd(input logic [5:0] addr, input logic [15:0] exp);
      op(`SEP_OPC_READ, addr, 16'h0000);
      `CHK(rd_data, exp)
      `CHK(din_sh[24:16], {1'b1, `SEP_OPC_READ, addr})
      `CHK(dout_sh, {1'b0, exp})
   endtask : rd

   // Power-up lock: every programming code refused
   task automatic t_locked();
      logic [1:0] opc [4];
      logic [5:0] adr [4];
      opc = '{`SEP_OPC_WRITE, `SEP_OPC_ERASE, `SEP_OPC_EXT, `SEP_OPC_EXT};
      adr = '{6'h07, 6'h07, {`SEP_SUB_WR_ALL, 4'h0}, {`SEP_SUB_ER_ALL, 4'h0}};
      busy_seen = 1'b0;
      for (int k = 0; k < 4; k++) begin
         op(opc[k], adr[k], 16'h0000);
      end
      `CHK(busy_seen, 1'b0)
      `CHK(prog_enabled, 1'b0)
      rd(6'h07, 16'hFFFF);
      $display("test locked done");
   endtask : t_locked

   task automatic t_write();
      op(`SEP_OPC_EXT, {`SEP_SUB_EN, 4'h5}, 16'h0000);
      `CHK(prog_enabled, 1'b1)
      op(`SEP_OPC_ERASE, 6'h2A, 16'h0000);
      busy_seen = 1'b0;
      stat_lo = 0;
      op(`SEP_OPC_WRITE, 6'h2A, 16'hA5C3);
      `CHK(busy_seen, 1'b1)
      `CHK(stat_lo > 0, 1'b1)
      `CHK(prog_busy, 1'b0)
      rd(6'h2A, 16'hA5C3);
      $display("test write done");
   endtask : t_write

   task automatic t_erase();
      op(`SEP_OPC_ERASE, 6'h2A, 16'h0000);
      rd(6'h2A, 16'hFFFF);
      $display("test erase done");
   endtask : t_erase

   task automatic t_every_word();
      op(`SEP_OPC_EXT, {`SEP_SUB_WR_ALL, 4'h9}, 16'h1234);
      rd(6'h00, 16'h1234);
      rd(6'h3F, 16'h1234);
      op(`SEP_OPC_EXT, {`SEP_SUB_ER_ALL, 4'h3}, 16'h0000);
      rd(6'h15, 16'hFFFF);
      $display("test every word done");
   endtask : t_every_word

   task automatic t_disable();
      op(`SEP_OPC_EXT, {`SEP_SUB_DIS, 4'hA}, 16'h0000);
      `CHK(prog_enabled, 1'b0)
      busy_seen = 1'b0;
      op(`SEP_OPC_WRITE, 6'h11, 16'h0000);
      `CHK(busy_seen, 1'b0)
      $display("test disable done");
   endtask : t_disable

   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      t_locked();
      t_write();
      t_erase();
      t_every_word();
      t_disable();
      test_done();
   end
endmodule : tb
